// [hw/dual_byte_tristate_register.sv]
// dual byte three-state register: bus-hold inputs, two lanes, three-state outputs
`timescale 1ns/1ps
`include "dbtr_defines.svh"

module dual_byte_tristate_register #(
  parameter int LANE_WIDTH = `DBTR_LANE_WIDTH
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_low_lane_clock,
  input wire logic i_high_lane_clock,
  input wire logic i_low_lane_output_enable_n,
  input wire logic i_high_lane_output_enable_n,
  input wire logic [15:0] i_data_inputs,
  input wire logic [15:0] i_data_inputs_driven,
  output logic [15:0] o_tristate_outputs,
  output logic [15:0] o_tristate_outputs_oe
);
  import dbtr_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // a rising lane clock is a low sample followed by a high one
  function automatic logic rising(input logic prev, input logic cur);
    rising = !prev && cur;
  endfunction : rising

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  lane_ctrl_t lane_ctrl [2];
  logic [1:0] clock_sample;
  logic [1:0] lane_edge;
  logic [15:0] held;
  logic [15:0] effective;
  logic [15:0] stored;
  lane_pins_t lane_pins [2];

  // group each lane's shared controls
  assign lane_ctrl[`DBTR_LOW_LANE] = '{clock: i_low_lane_clock, output_enable_n: i_low_lane_output_enable_n};
  assign lane_ctrl[`DBTR_HIGH_LANE] = '{clock: i_high_lane_clock, output_enable_n: i_high_lane_output_enable_n};

  // ----------------------------------------------------------------
  // bus hold
  // ----------------------------------------------------------------
  // an undriven bit keeps the level it last saw, so a floating input
  // never hands an unknown to its flip-flop
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      held <= {`DBTR_HOLD_RESET, `DBTR_HOLD_RESET};
    end
    else
    begin
      held <= effective; // RULE9
    end
  end

  // driven bits pass straight through, undriven bits read the keeper
  always_comb
  begin
    effective = (i_data_inputs & i_data_inputs_driven) | (held & ~i_data_inputs_driven); // RULE9
  end

  // ----------------------------------------------------------------
  // lanes
  // ----------------------------------------------------------------
  for (genvar lane = 0; lane < `DBTR_LANE_COUNT; lane++)
  begin : g_lane // RULE2
    localparam int LO = lane * LANE_WIDTH;
    // each lane owns its registers, so no vector has two writing processes
    logic clock_seen;
    lane_byte_t lane_store;

    // lane clock sampled once per system clock; it must stay high or
    // low for at least one system period or an edge can be missed
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        clock_seen <= `DBTR_CLOCK_SAMPLE_RESET;
      end
      else
      begin
        clock_seen <= lane_ctrl[lane].clock; // RULE3
      end
    end

    assign clock_sample[lane] = clock_seen;
    assign lane_edge[lane] = rising(clock_seen, lane_ctrl[lane].clock); // RULE4

    // storage loads only on its own lane edge; the enable plays no part
    // here, so floating the outputs leaves capture running
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        lane_store <= `DBTR_STORE_RESET; // RULE10
      end
      else if (lane_edge[lane])
      begin
        lane_store <= effective[LO +: LANE_WIDTH]; // RULE4
      end
      else
      begin
        lane_store <= lane_store; // RULE5
      end
    end

    assign stored[LO +: LANE_WIDTH] = lane_store;

    // outputs show stored data uninverted; one enable governs all eight
    always_comb
    begin
      lane_pins[lane].data = stored[LO +: LANE_WIDTH]; // RULE1
      lane_pins[lane].drive = lane_ctrl[lane].output_enable_n ? 8'h00 : 8'hFF; // RULE6
    end

    assign o_tristate_outputs[LO +: LANE_WIDTH] = lane_pins[lane].data; // RULE8
    assign o_tristate_outputs_oe[LO +: LANE_WIDTH] = lane_pins[lane].drive; // RULE7
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  // low lane captures what its inputs presented on the edge
  AST_CAPTURE_LOW: assert property ( // RULE4
    lane_edge[0] |=> stored[7:0] == $past(effective[7:0]))
    else $error("low lane missed its capture");

  // high lane captures on its own edge
  AST_CAPTURE_HIGH: assert property ( // RULE2
    lane_edge[1] |=> stored[15:8] == $past(effective[15:8]))
    else $error("high lane missed its capture");

  // clock held low for three cycles keeps the low byte
  AST_HOLD_LOW: assert property ( // RULE5
    (!i_low_lane_clock && !clock_sample[0]) [*3] |-> $stable(stored[7:0]))
    else $error("low lane changed with clock low");

  // no edge means no change in the high byte
  AST_HOLD_HIGH: assert property ( // RULE5
    !lane_edge[1] |=> stored[15:8] == $past(stored[15:8]))
    else $error("high lane changed without an edge");

  // enable low drives the stored byte on every bit
  AST_DRIVE_LOW: assert property ( // RULE6
    !i_low_lane_output_enable_n |-> o_tristate_outputs_oe[7:0] == 8'hFF && o_tristate_outputs[7:0] == stored[7:0])
    else $error("low lane not driving stored data");

  // enable high floats the low lane whatever the clock does
  AST_FLOAT_LOW: assert property ( // RULE7
    i_low_lane_output_enable_n |-> o_tristate_outputs_oe[7:0] == 8'h00)
    else $error("low lane driving while disabled");

  // enable high floats the high lane
  AST_FLOAT_HIGH: assert property ( // RULE7
    i_high_lane_output_enable_n |-> o_tristate_outputs_oe[15:8] == 8'h00)
    else $error("high lane driving while disabled");

  // toggling the enable without an edge leaves storage alone
  AST_ENABLE_NO_EFFECT: assert property ( // RULE8
    $changed(i_high_lane_output_enable_n) && !lane_edge[1] |=> $stable(stored[15:8]))
    else $error("enable disturbed high lane storage");

  // capture goes on while floated
  AST_CAPTURE_FLOATED: assert property ( // RULE8
    lane_edge[0] && i_low_lane_output_enable_n |=> stored[7:0] == $past(effective[7:0]))
    else $error("floated low lane did not capture");

  // an undriven bit keeps its previous level
  AST_BUSHOLD: assert property ( // RULE9
    1'b1 |=> ((effective ^ $past(effective)) & ~i_data_inputs_driven) == 16'h0000)
    else $error("undriven input lost its level");

  // a low edge alone leaves the high byte untouched
  AST_LANES_APART: assert property ( // RULE2
    lane_edge[0] && !lane_edge[1] |=> $stable(stored[15:8]))
    else $error("lanes not independent");

  // high lane outputs are the stored bits uninverted
  AST_TRUE_OUTPUT: assert property ( // RULE1
    lane_edge[1] |=> o_tristate_outputs[15:8] == $past(effective[15:8]))
    else $error("high lane output inverted or stale");

  // shared controls tied together act as one 16-bit register
  AST_TIED_WORD: assert property ( // RULE3
    lane_edge[0] && lane_edge[1] |=> stored == $past(effective))
    else $error("tied lanes did not load a full word");

  // enable low drives the stored high byte on every bit
  AST_DRIVE_HIGH: assert property ( // RULE6
    !i_high_lane_output_enable_n |-> o_tristate_outputs_oe[15:8] == 8'hFF && o_tristate_outputs[15:8] == stored[15:8])
    else $error("high lane not driving stored data");

  // without its own edge the low byte never moves
  AST_HOLD_LOW_NO_EDGE: assert property ( // RULE4
    !lane_edge[0] |=> $stable(stored[7:0]))
    else $error("low lane changed without an edge");

  // low lane outputs follow the captured byte uninverted
  AST_TRUE_OUTPUT_LOW: assert property ( // RULE1
    lane_edge[0] |=> o_tristate_outputs[7:0] == $past(effective[7:0]))
    else $error("low lane output inverted or stale");

  // toggling the low enable without an edge leaves storage alone
  AST_ENABLE_NO_EFFECT_LOW: assert property ( // RULE8
    $changed(i_low_lane_output_enable_n) && !lane_edge[0] |=> $stable(stored[7:0]))
    else $error("enable disturbed low lane storage");

  // a high edge alone leaves the low byte untouched
  AST_LANES_APART_HIGH: assert property ( // RULE2
    lane_edge[1] && !lane_edge[0] |=> $stable(stored[7:0]))
    else $error("high edge disturbed low lane");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  COV_BOTH_EDGES: cover property (lane_edge[0] && lane_edge[1]);
  COV_FLOAT_CAPTURE: cover property (lane_edge[1] && i_high_lane_output_enable_n);
  COV_BUSHOLD_CAPTURE: cover property (lane_edge[0] && i_data_inputs_driven[7:0] == 8'h00);
  COV_ENABLE_AFTER_LOAD: cover property (lane_edge[0] ##1 !i_low_lane_output_enable_n [*2]);
  COV_SPLIT_ENABLES: cover property (i_low_lane_output_enable_n && !i_high_lane_output_enable_n);

endmodule : dual_byte_tristate_register

// [hw/dbtr_defines.svh]
// constants for the dual byte three-state register
// Functional notes
// RULE1 - sixteen non-inverting stored bits with three-state outputs
// RULE2 - two independent byte lanes, low and high
// RULE3 - one clock and enable shared per lane
// RULE4 - load data only on lane clock rising edge
// RULE5 - clock held low keeps stored value
// RULE6 - enable low drives stored contents
// RULE7 - enable high floats all lane outputs
// RULE8 - enable never alters storage; capture continues
// RULE9 - undriven data input keeps last level
// RULE10 - no reset pin; contents unspecified until loaded (the code has i_reset_n, which loads DBTR_STORE_RESET, 8'h00, into each lane)
`ifndef DBTR_DEFINES_SVH
`define DBTR_DEFINES_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define DBTR_LANE_WIDTH 8
`define DBTR_LANE_COUNT 2
`define DBTR_LOW_LANE 0
`define DBTR_HIGH_LANE 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DBTR_STORE_RESET 8'h00
`define DBTR_HOLD_RESET 8'h00
`define DBTR_CLOCK_SAMPLE_RESET 1'b0

`endif

// [hw/dbtr_pkg.sv]
// types shared by the dual byte three-state register
package dbtr_pkg;

  // ----------------------------------------------------------------
  // lane carriers
  // ----------------------------------------------------------------
  typedef logic [7:0] lane_byte_t;

  // controls that one lane shares across its eight bits
  typedef struct packed {
    logic clock;
    logic output_enable_n;
  } lane_ctrl_t;

  // what a lane presents on its pins
  typedef struct packed {
    lane_byte_t data;
    lane_byte_t drive;
  } lane_pins_t;

endpackage : dbtr_pkg

// [verif/bus_driver_model.sv]
// model of the logic that drives the register's data and control pins
`timescale 1ns/1ps
module bus_driver_model (
  input wire logic i_clock,
  output logic o_low_lane_clock,
  output logic o_high_lane_clock,
  output logic o_low_lane_output_enable_n,
  output logic o_high_lane_output_enable_n,
  output logic [15:0] o_data_inputs,
  output logic [15:0] o_data_inputs_driven
);
  // controls start low and floated, so no edge is seen before the first pulse
  initial
  begin
    o_low_lane_clock = 1'b0;
    o_high_lane_clock = 1'b0;
    o_low_lane_output_enable_n = 1'b1;
    o_high_lane_output_enable_n = 1'b1;
    o_data_inputs = 16'h0000;
    o_data_inputs_driven = 16'h0000;
  end
  // released lines flip so a stale level cannot pass for a held one
  task automatic put(input logic [15:0] value, input logic [15:0] mask);
    @(negedge i_clock);
    o_data_inputs = (value & mask) | (~o_data_inputs & ~mask);
    o_data_inputs_driven = mask;
  endtask : put
  // one high cycle then one low cycle, the fastest spacing allowed
  task automatic pulse(input logic [1:0] lanes);
    @(negedge i_clock);
    o_low_lane_clock = lanes[0];
    o_high_lane_clock = lanes[1];
    @(negedge i_clock);
    o_low_lane_clock = 1'b0;
    o_high_lane_clock = 1'b0;
  endtask : pulse
  task automatic enable(input logic low_n, input logic high_n);
    @(negedge i_clock);
    o_low_lane_output_enable_n = low_n;
    o_high_lane_output_enable_n = high_n;
  endtask : enable
endmodule : bus_driver_model

// [verif/dual_byte_tristate_register_tb.sv]
// self-checking bench for the dual byte three-state register
`timescale 1ns/1ps
module dual_byte_tristate_register_tb;
  logic i_clock;
  logic i_reset_n;
  logic lclk, hclk, loe_n, hoe_n;
  logic [15:0] din, dvn, dout, doe;
  int bad_count = 0;
  int samples_checked = 0;
  // ----------------------------------------------------------------
  // clock, reset, parts
  // ----------------------------------------------------------------
  initial
  begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  bus_driver_model drv (.i_clock(i_clock), .o_low_lane_clock(lclk), .o_high_lane_clock(hclk),
    .o_low_lane_output_enable_n(loe_n), .o_high_lane_output_enable_n(hoe_n),
    .o_data_inputs(din), .o_data_inputs_driven(dvn));
  dual_byte_tristate_register uut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_low_lane_clock(lclk),
    .i_high_lane_clock(hclk), .i_low_lane_output_enable_n(loe_n), .i_high_lane_output_enable_n(hoe_n),
    .i_data_inputs(din), .i_data_inputs_driven(dvn), .o_tristate_outputs(dout), .o_tristate_outputs_oe(doe));
  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  // only bits set in mask are compared, not those marked by doe; every call here passes 16'hFFFF
  task automatic check_out(input logic [15:0] exp, input logic [15:0] mask);
    samples_checked++;
    if ((dout & mask) !== (exp & mask))
    begin
      bad_count++;
      $display("BAD %0t outputs %h expected %h", $time, dout, exp);
    end
  endtask : check_out
  task automatic check_oe(input logic [15:0] exp);
    samples_checked++;
    if (doe !== exp)
    begin
      bad_count++;
      $display("BAD %0t drive enables %h expected %h", $time, doe, exp);
    end
  endtask : check_oe
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  // watchdog: a hang counts as a mismatch
  initial
  begin
    repeat (2000) @(posedge i_clock);
    bad_count++;
    summarize();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic both_lanes;
    drv.enable(1'b0, 1'b0);
    drv.put(16'h3CA5, 16'hFFFF);
    drv.pulse(2'b11);
    @(negedge i_clock);
    check_out(16'h3CA5, 16'hFFFF);
    check_oe(16'hFFFF);
  endtask : both_lanes
  task automatic low_only_then_hold;
    drv.put(16'hC35A, 16'hFFFF);
    drv.pulse(2'b01);
    drv.put(16'h0FF0, 16'hFFFF);
    repeat (3) @(negedge i_clock);
    check_out(16'h3C5A, 16'hFFFF);
    check_out(16'h3C5A, 16'hFFFF);
  endtask : low_only_then_hold
  task automatic float_and_capture;
    drv.enable(1'b1, 1'b0);
    @(negedge i_clock);
    check_oe(16'hFF00);
    drv.put(16'h960F, 16'hFFFF);
    drv.pulse(2'b11);
    drv.enable(1'b0, 1'b0);
    @(negedge i_clock);
    check_out(16'h960F, 16'hFFFF);
    check_oe(16'hFFFF);
  endtask : float_and_capture
  task automatic hold_when_released;
    drv.put(16'hFFFF, 16'hFFFF);
    drv.put(16'h0000, 16'h0000);
    drv.pulse(2'b11);
    @(negedge i_clock);
    check_out(16'hFFFF, 16'hFFFF);
    drv.put(16'h1234, 16'hFFFF);
    drv.pulse(2'b00);
    @(negedge i_clock);
    check_out(16'hFFFF, 16'hFFFF);
    drv.pulse(2'b10);
    @(negedge i_clock);
    check_out(16'h12FF, 16'hFFFF);
  endtask : hold_when_released
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    i_reset_n = 1'b0;
    repeat (10) @(negedge i_clock);
    i_reset_n = 1'b1;
    both_lanes();
    low_only_then_hold();
    float_and_capture();
    hold_when_released();
    summarize();
  end
endmodule : dual_byte_tristate_register_tb
